// ==== rtl/dwit_defs.svh ====
// register map, keys, field positions, reset values and tap table
`ifndef DWIT_DEFS_SVH
`define DWIT_DEFS_SVH

`define DWIT_NCH          2
`define DWIT_CNT_W        8
`define DWIT_PS_W         17
`define DWIT_LG_W         5
`define DWIT_EV_W         6
`define DWIT_ADDR_W       5
`define DWIT_DATA_W       32
`define DWIT_STRB_W       4

`define DWIT_OFF_CNT0     5'h00
`define DWIT_OFF_CSR0     5'h04
`define DWIT_OFF_CNT1     5'h08
`define DWIT_OFF_CSR1     5'h0c
`define DWIT_OFF_STAT     5'h10
`define DWIT_OFF_CLR      5'h14
`define DWIT_OFF_EN       5'h18
`define DWIT_OFF_ACT0     5'h1c

`define DWIT_KEY_CNT      8'h5a
`define DWIT_KEY_CSR      8'ha5
`define DWIT_KEY_HI       15
`define DWIT_KEY_LO       8
`define DWIT_KEY_STRB     2'b11

`define DWIT_B_OVF        7
`define DWIT_B_MODE       6
`define DWIT_B_RUN        5
`define DWIT_B_PSS        4
`define DWIT_B_RSTSEL     3
`define DWIT_CKS_HI       2
`define DWIT_RESV_CH0     2'b11
`define DWIT_CH1          1

`define DWIT_CNT_RST      8'h00
`define DWIT_CNT_MAX      8'hff

`define DWIT_EV_ITV       0
`define DWIT_EV_NMI       2
`define DWIT_EV_RST       4

`define DWIT_RESP_OKAY    2'b00
`define DWIT_RESP_SLVERR  2'b10

`define DWIT_LG_C0        5'h01
`define DWIT_LG_C1        5'h06
`define DWIT_LG_C2        5'h07
`define DWIT_LG_C4        5'h0b
`define DWIT_LG_C6        5'h0f
`define DWIT_LG_C7        5'h11

`endif

// ==== rtl/dwit_pkg.sv ====
// shared types of the dual watchdog / interval timer
`include "dwit_defs.svh"
`default_nettype none

package dwit_pkg;

  typedef enum logic [1:0]
  {
    ACT_NONE  = 2'b00,
    ACT_RESET = 2'b01,
    ACT_NMI   = 2'b10
  } dwit_act_e;

  typedef struct packed {
    logic [`DWIT_NCH-1:0][`DWIT_CNT_W-1:0] cnt;
    logic [`DWIT_NCH-1:0]                  ovf;
    logic [`DWIT_NCH-1:0]                  mode;
    logic [`DWIT_NCH-1:0]                  run;
    logic [`DWIT_NCH-1:0][`DWIT_CKS_HI:0]  cks;
    logic [`DWIT_NCH-1:0]                  armed;
    logic                                  pss1;
    logic                                  rsel1;
    dwit_act_e                             act0;
    logic [`DWIT_EV_W-1:0]                 stat;
    logic [`DWIT_EV_W-1:0]                 en;
    logic                                  irq;
    logic [`DWIT_NCH-1:0]                  itv;
    logic [`DWIT_NCH-1:0]                  nmi;
    logic [`DWIT_NCH-1:0]                  rst;
    logic [`DWIT_PS_W-1:0]                 ps_main;
    logic [`DWIT_PS_W-1:0]                 ps_sub;
    logic [2:0]                            sub_sync;
    logic                                  awrdy;
    logic                                  wrdy;
    logic                                  bvalid;
    logic                                  arrdy;
    logic                                  rvalid;
    logic [`DWIT_ADDR_W-1:0]               aw_addr;
    logic [`DWIT_DATA_W-1:0]               w_data;
    logic [`DWIT_STRB_W-1:0]               w_strb;
    logic [1:0]                            bresp;
    logic [1:0]                            rresp;
    logic [`DWIT_DATA_W-1:0]               rdata;
  } dwit_state_s;

endpackage : dwit_pkg

`default_nettype wire

// ==== rtl/dwit_top.sv ====
// dual-channel watchdog / interval timer with axi4-lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`default_nettype none

module dwit_top
#(
  parameter logic [`DWIT_LG_W-1:0] LG_DIV_CODE3 = 5'h09,
  parameter logic [`DWIT_LG_W-1:0] LG_DIV_CODE5 = 5'h0d
)
(
  // clock and reset
  input  wire logic                     CLK,
  input  wire logic                     SRST,
  // sub-clock, asynchronous
  input  wire logic                     SUB_CLK,
  // axi4-lite write address
  input  wire logic                     AWVALID,
  output logic                          AWREADY,
  input  wire logic [`DWIT_ADDR_W-1:0]  AWADDR,
  // axi4-lite write data
  input  wire logic                     WVALID,
  output logic                          WREADY,
  input  wire logic [`DWIT_DATA_W-1:0]  WDATA,
  input  wire logic [`DWIT_STRB_W-1:0]  WSTRB,
  // axi4-lite write response
  output logic                          BVALID,
  input  wire logic                     BREADY,
  output logic [1:0]                    BRESP,
  // axi4-lite read address
  input  wire logic                     ARVALID,
  output logic                          ARREADY,
  input  wire logic [`DWIT_ADDR_W-1:0]  ARADDR,
  // axi4-lite read data
  output logic                          RVALID,
  input  wire logic                     RREADY,
  output logic [`DWIT_DATA_W-1:0]       RDATA,
  output logic [1:0]                    RRESP,
  // timer requests
  output logic [`DWIT_NCH-1:0]          INTERVAL_IRQ,
  output logic [`DWIT_NCH-1:0]          NMI_REQ,
  output logic [`DWIT_NCH-1:0]          RESET_REQ,
  output logic                          IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // state and working signals

  dwit_pkg::dwit_state_s s_q;
  dwit_pkg::dwit_state_s s_d;

  logic [`DWIT_NCH-1:0]    tick;
  logic [`DWIT_NCH-1:0]    ovf_ev;
  logic [`DWIT_NCH-1:0]    wr_cnt;
  logic [`DWIT_NCH-1:0]    wr_csr;
  logic [`DWIT_NCH-1:0]    clr_ovf;
  logic [`DWIT_EV_W-1:0]   ev;
  logic [`DWIT_EV_W-1:0]   clr_ev;
  logic                    sub_edge;
  logic                    wr_fire;
  logic                    rd_err;
  logic [`DWIT_DATA_W:0]   rd_word;
  dwit_pkg::dwit_act_e     act;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // divider exponent for a clock-select code
  function automatic logic [`DWIT_LG_W-1:0] tap_lg
  (
    input logic [`DWIT_CKS_HI:0] code
  );
    logic [`DWIT_LG_W-1:0] lg;
    lg = `DWIT_LG_C0;
    case (code)
      3'h0:    lg = `DWIT_LG_C0;
      3'h1:    lg = `DWIT_LG_C1;
      3'h2:    lg = `DWIT_LG_C2;
      3'h3:    lg = LG_DIV_CODE3;
      3'h4:    lg = `DWIT_LG_C4;
      3'h5:    lg = LG_DIV_CODE5;
      3'h6:    lg = `DWIT_LG_C6;
      default: lg = `DWIT_LG_C7;
    endcase
    return lg;
  endfunction : tap_lg

  // one pulse per 2**lg prescaler steps
  function automatic logic tap_tick
  (
    input logic [`DWIT_PS_W-1:0] ps,
    input logic [`DWIT_LG_W-1:0] lg
  );
    logic [`DWIT_PS_W-1:0] mask;
    mask = (`DWIT_PS_W'(1) << lg) - `DWIT_PS_W'(1);
    return &(ps | ~mask);
  endfunction : tap_tick

  // protected write: both low lanes and the matching key
  function automatic logic key_ok
  (
    input logic [`DWIT_DATA_W-1:0] d,
    input logic [`DWIT_STRB_W-1:0] st,
    input logic [7:0]              key
  );
    return (st[1:0] == `DWIT_KEY_STRB) &&
           (d[`DWIT_KEY_HI:`DWIT_KEY_LO] == key);
  endfunction : key_ok

  // control/status byte of a channel
  function automatic logic [`DWIT_CNT_W-1:0] csr_byte
  (
    input dwit_pkg::dwit_state_s st,
    input int                    n
  );
    logic [`DWIT_CNT_W-1:0] v;
    v = {st.ovf[n], st.mode[n], st.run[n], `DWIT_RESV_CH0, st.cks[n]};
    if (n == `DWIT_CH1)
    begin
      v[`DWIT_B_PSS]    = st.pss1;
      v[`DWIT_B_RSTSEL] = st.rsel1;
    end
    return v;
  endfunction : csr_byte

  // watchdog overflow action of a channel
  function automatic dwit_pkg::dwit_act_e chan_act
  (
    input dwit_pkg::dwit_state_s st,
    input int                    n
  );
    dwit_pkg::dwit_act_e a;
    a = st.act0;
    if (n == `DWIT_CH1)
      a = st.rsel1 ? dwit_pkg::ACT_RESET : dwit_pkg::ACT_NMI;
    return a;
  endfunction : chan_act

  // read decode: error flag on top, data below
  function automatic logic [`DWIT_DATA_W:0] read_dec
  (
    input logic [`DWIT_ADDR_W-1:0] a,
    input dwit_pkg::dwit_state_s   st
  );
    logic [`DWIT_DATA_W:0] r;
    r = '0;
    if (a == `DWIT_OFF_CNT0)
      r[`DWIT_CNT_W-1:0] = st.cnt[0];
    else if (a == `DWIT_OFF_CNT1)
      r[`DWIT_CNT_W-1:0] = st.cnt[`DWIT_CH1];
    else if (a == `DWIT_OFF_CSR0)
      r[`DWIT_CNT_W-1:0] = csr_byte(st, 0);
    else if (a == `DWIT_OFF_CSR1)
      r[`DWIT_CNT_W-1:0] = csr_byte(st, `DWIT_CH1);
    else if (a == `DWIT_OFF_STAT)
      r[`DWIT_EV_W-1:0] = st.stat;
    else if (a == `DWIT_OFF_EN)
      r[`DWIT_EV_W-1:0] = st.en;
    else if (a == `DWIT_OFF_ACT0)
      r[1:0] = st.act0;
    else if (a == `DWIT_OFF_CLR)
      r = '0;
    else
      r[`DWIT_DATA_W] = 1'b1;
    return r;
  endfunction : read_dec

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    s_d      = s_q;
    tick     = '0;
    ovf_ev   = '0;
    wr_cnt   = '0;
    wr_csr   = '0;
    clr_ovf  = '0;
    ev       = '0;
    clr_ev   = '0;
    act      = dwit_pkg::ACT_NONE;
    rd_word  = '0;
    rd_err   = 1'b0;
    sub_edge = s_q.sub_sync[1] & ~s_q.sub_sync[2];

    // prescalers; sub-clock sampled through two flops first
    s_d.ps_main  = s_q.ps_main + `DWIT_PS_W'(1);
    s_d.sub_sync = {s_q.sub_sync[1:0], SUB_CLK};
    if (sub_edge)
      s_d.ps_sub = s_q.ps_sub + `DWIT_PS_W'(1);

    // eight taps on each channel; channel 1 can tap either prescaler
    tick[0] = tap_tick(s_q.ps_main, tap_lg(s_q.cks[0]));
    if (s_q.pss1)
      tick[`DWIT_CH1] = sub_edge &
                        tap_tick(s_q.ps_sub, tap_lg(s_q.cks[`DWIT_CH1]));
    else
      tick[`DWIT_CH1] = tap_tick(s_q.ps_main, tap_lg(s_q.cks[`DWIT_CH1]));

    // write address and data taken in either order
    if (AWVALID && s_q.awrdy)
    begin
      s_d.awrdy   = 1'b0;
      s_d.aw_addr = AWADDR;
    end
    if (WVALID && s_q.wrdy)
    begin
      s_d.wrdy   = 1'b0;
      s_d.w_data = WDATA;
      s_d.w_strb = WSTRB;
    end

    // write decode once both halves are held
    wr_fire = !s_q.awrdy && !s_q.wrdy && !s_q.bvalid;
    if (wr_fire)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = `DWIT_RESP_OKAY;
      // counter and control need the protected write
      // key per register in bits 15:8
      if (s_q.aw_addr == `DWIT_OFF_CNT0)
        wr_cnt[0] = key_ok(s_q.w_data, s_q.w_strb, `DWIT_KEY_CNT);
      else if (s_q.aw_addr == `DWIT_OFF_CNT1)
        wr_cnt[`DWIT_CH1] = key_ok(s_q.w_data, s_q.w_strb, `DWIT_KEY_CNT);
      else if (s_q.aw_addr == `DWIT_OFF_CSR0)
        wr_csr[0] = key_ok(s_q.w_data, s_q.w_strb, `DWIT_KEY_CSR);
      else if (s_q.aw_addr == `DWIT_OFF_CSR1)
        wr_csr[`DWIT_CH1] = key_ok(s_q.w_data, s_q.w_strb, `DWIT_KEY_CSR);
      else if (s_q.aw_addr == `DWIT_OFF_CLR)
      begin
        if (s_q.w_strb[0])
          clr_ev = s_q.w_data[`DWIT_EV_W-1:0];
      end
      else if (s_q.aw_addr == `DWIT_OFF_EN)
      begin
        if (s_q.w_strb[0])
          s_d.en = s_q.w_data[`DWIT_EV_W-1:0];
      end
      else if (s_q.aw_addr == `DWIT_OFF_ACT0)
      begin
        if (s_q.w_strb[0])
        begin
          if (s_q.w_data[1:0] == dwit_pkg::ACT_RESET)
            s_d.act0 = dwit_pkg::ACT_RESET;
          else if (s_q.w_data[1:0] == dwit_pkg::ACT_NMI)
            s_d.act0 = dwit_pkg::ACT_NMI;
          else
            s_d.act0 = dwit_pkg::ACT_NONE;
        end
      end
      else if (s_q.aw_addr != `DWIT_OFF_STAT)
        s_d.bresp = `DWIT_RESP_SLVERR;
    end
    if (s_q.bvalid && BREADY)
    begin
      s_d.bvalid = 1'b0;
      s_d.awrdy  = 1'b1;
      s_d.wrdy   = 1'b1;
    end

    // channel control writes
    for (int n = 0; n < `DWIT_NCH; n++)
    begin
      if (wr_csr[n])
      begin
        s_d.mode[n] = s_q.w_data[`DWIT_B_MODE];
        s_d.run[n]  = s_q.w_data[`DWIT_B_RUN];
        s_d.cks[n]  = s_q.w_data[`DWIT_CKS_HI:0];
        if (!s_q.w_data[`DWIT_B_OVF] && s_q.armed[n])
          clr_ovf[n] = 1'b1;
        s_d.armed[n] = 1'b0;
      end
    end
    if (wr_csr[`DWIT_CH1])
    begin
      s_d.pss1  = s_q.w_data[`DWIT_B_PSS];
      s_d.rsel1 = s_q.w_data[`DWIT_B_RSTSEL];
    end

    // counters, flags and requests
    for (int n = 0; n < `DWIT_NCH; n++)
    begin
      // wrap from all ones; a counter write suppresses it
      ovf_ev[n] = s_q.run[n] && tick[n] && !wr_cnt[n] &&
                  (s_q.cnt[n] == `DWIT_CNT_MAX);
      if (!s_q.run[n])
        s_d.cnt[n] = `DWIT_CNT_RST;
      else if (wr_cnt[n])
        s_d.cnt[n] = s_q.w_data[`DWIT_CNT_W-1:0];
      else if (tick[n])
        s_d.cnt[n] = s_q.cnt[n] + `DWIT_CNT_W'(1);

      // flag cleared by the reset request
      s_d.ovf[n] = ovf_ev[n] |
                   (s_q.ovf[n] & ~clr_ovf[n] & ~s_q.rst[n]);

      act = chan_act(s_q, n);
      s_d.rst[n] = ovf_ev[n] && s_q.mode[n] &&
                   (act == dwit_pkg::ACT_RESET);
      s_d.nmi[n] = ovf_ev[n] && s_q.mode[n] &&
                   (act == dwit_pkg::ACT_NMI);

      ev[`DWIT_EV_ITV + n] = ovf_ev[n] && !s_q.mode[n];
      ev[`DWIT_EV_NMI + n] = s_d.nmi[n];
      ev[`DWIT_EV_RST + n] = s_d.rst[n];

      s_d.itv[n] = s_d.ovf[n] && !s_d.mode[n];
    end

    // read channel; a read of a set flag arms its clear
    if (ARVALID && s_q.arrdy)
    begin
      rd_word    = read_dec(ARADDR, s_q);
      rd_err     = rd_word[`DWIT_DATA_W];
      s_d.rdata  = rd_word[`DWIT_DATA_W-1:0];
      s_d.rresp  = rd_err ? `DWIT_RESP_SLVERR : `DWIT_RESP_OKAY;
      s_d.arrdy  = 1'b0;
      s_d.rvalid = 1'b1;
      if (ARADDR == `DWIT_OFF_CSR0 && s_q.ovf[0])
        s_d.armed[0] = 1'b1;
      if (ARADDR == `DWIT_OFF_CSR1 && s_q.ovf[`DWIT_CH1])
        s_d.armed[`DWIT_CH1] = 1'b1;
    end
    if (s_q.rvalid && RREADY)
    begin
      s_d.rvalid = 1'b0;
      s_d.arrdy  = 1'b1;
    end

    // sticky status, set wins over clear
    s_d.stat = (s_q.stat & ~clr_ev) | ev;
    s_d.irq  = |(s_d.stat & s_d.en);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      s_q       <= '0;
      s_q.awrdy <= 1'b1;
      s_q.wrdy  <= 1'b1;
      s_q.arrdy <= 1'b1;
      s_q.act0  <= dwit_pkg::ACT_NONE;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign AWREADY      = s_q.awrdy;
  assign WREADY       = s_q.wrdy;
  assign BVALID       = s_q.bvalid;
  assign BRESP        = s_q.bresp;
  assign ARREADY      = s_q.arrdy;
  assign RVALID       = s_q.rvalid;
  assign RDATA        = s_q.rdata;
  assign RRESP        = s_q.rresp;
  assign INTERVAL_IRQ = s_q.itv;
  assign NMI_REQ      = s_q.nmi;
  assign RESET_REQ    = s_q.rst;
  assign IRQ          = s_q.irq;

endmodule : dwit_top

`default_nettype wire

// ==== bench/dwit_top_asserts.sv ====
// port-level concurrent checks of the dual watchdog / interval timer
`default_nettype none

module dwit_asserts
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // register bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  // timer requests
  input wire logic [1:0]  INTERVAL_IRQ,
  input wire logic [1:0]  NMI_REQ,
  input wire logic [1:0]  RESET_REQ,
  input wire logic        IRQ
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  sequence s_wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_rd_taken;
    ARVALID && ARREADY;
  endsequence

  //////////////////////////////////////////////////////////////////////////
  chk_rst_quiet: assert property (
    $fell(SRST) |-> AWREADY && WREADY && ARREADY && !BVALID && !RVALID
      && !IRQ && (INTERVAL_IRQ | NMI_REQ | RESET_REQ) == 2'h0)
    else $error("outputs not idle after reset");
  chk_wr_answer: assert property (
    s_wr_taken |=> !BVALID ##1 BVALID)
    else $error("write response not on second edge");
  chk_wr_hold: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");
  chk_wr_busy: assert property (
    s_wr_taken |=> (!AWREADY && !WREADY) [*2])
    else $error("write channels ready while busy");
  chk_rd_answer: assert property (
    s_rd_taken |=> RVALID && !ARREADY)
    else $error("read data not one edge after address");
  chk_rd_hold: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before taken");
  chk_nmi_pulse: assert property (
    (NMI_REQ & $past(NMI_REQ)) == 2'h0)
    else $error("nmi request longer than one cycle");
  chk_rst_pulse: assert property (
    RESET_REQ != 2'h0 |=> RESET_REQ == 2'h0)
    else $error("reset request longer than one cycle");
  chk_req_excl: assert property (
    (NMI_REQ & RESET_REQ) == 2'h0
      && (INTERVAL_IRQ & (NMI_REQ | RESET_REQ)) == 2'h0)
    else $error("interval and watchdog requests together");

endmodule : dwit_asserts

bind dwit_top dwit_asserts u_asserts
(
  .CLK(CLK), .SRST(SRST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
  .RREADY(RREADY), .RDATA(RDATA), .INTERVAL_IRQ(INTERVAL_IRQ),
  .NMI_REQ(NMI_REQ), .RESET_REQ(RESET_REQ), .IRQ(IRQ)
);

`default_nettype wire

// ==== bench/dwit_top_tb.sv ====
// self-checking bench of the dual watchdog / interval timer
`include "dwit_defs.svh"
`default_nettype none

module dual_channel_watchdog_interval_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [4:0]  a;
    logic        w;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] e;
    logic [1:0]  r;
  } dwit_row_s;

  localparam logic [1:0] okay   = `DWIT_RESP_OKAY;
  localparam logic [1:0] slverr = `DWIT_RESP_SLVERR;

  logic        CLK, SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [4:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rs, INTERVAL_IRQ, NMI_REQ, RESET_REQ;
  logic [2:0]  sub_cnt = 3'h0;
  wire logic   SUB_CLK;
  wire logic [3:0] reqs;
  int          miscompares, n_checks, n;

  dwit_row_s rows [16] = '{
    '{`DWIT_OFF_CSR0, 1'h1, 32'ha507, 4'hf, 32'h1f, okay},
    '{`DWIT_OFF_CSR0, 1'h1, 32'ha5ff, 4'hf, 32'h7f, okay},
    '{`DWIT_OFF_CNT0, 1'h1, 32'h5a80, 4'hf, 32'h80, okay},
    '{`DWIT_OFF_CNT0, 1'h1, 32'h0011, 4'hf, 32'h80, okay},
    '{`DWIT_OFF_CNT0, 1'h1, 32'h5a22, 4'h1, 32'h80, okay},
    '{`DWIT_OFF_CSR0, 1'h1, 32'h3c40, 4'hf, 32'h7f, okay},
    '{`DWIT_OFF_CSR1, 1'h1, 32'ha518, 4'hf, 32'h18, okay},
    '{`DWIT_OFF_STAT, 1'h1, 32'h003f, 4'hf, 32'h00, okay},
    '{`DWIT_OFF_EN,   1'h1, 32'h003f, 4'hf, 32'h3f, okay},
    '{`DWIT_OFF_CLR,  1'h1, 32'h0000, 4'hf, 32'h00, okay},
    '{`DWIT_OFF_ACT0, 1'h1, 32'h0003, 4'hf, 32'h00, okay},
    '{`DWIT_OFF_ACT0, 1'h1, 32'h0001, 4'hf, 32'h01, okay},
    '{`DWIT_OFF_ACT0, 1'h1, 32'h0002, 4'hf, 32'h02, okay},
    '{5'h02,          1'h1, 32'h0000, 4'hf, 32'h00, slverr},
    '{`DWIT_OFF_CSR0, 1'h1, 32'ha540, 4'hf, 32'h58, okay},
    '{`DWIT_OFF_CNT0, 1'h0, 32'h0000, 4'h0, 32'h00, okay}
  };

  dwit_top uut
  (
    .CLK(CLK), .SRST(SRST), .SUB_CLK(SUB_CLK),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .INTERVAL_IRQ(INTERVAL_IRQ), .NMI_REQ(NMI_REQ),
    .RESET_REQ(RESET_REQ), .IRQ(IRQ)
  );

  assign reqs    = {RESET_REQ, NMI_REQ};
  assign SUB_CLK = sub_cnt[2];

  initial
  begin
    CLK = 1'h0;
    forever #50 CLK = ~CLK;
  end

  // sub-clock of eight system cycles
  always @(posedge CLK) sub_cnt <= sub_cnt + 3'h1;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    @(posedge CLK);
    AWADDR  <= a;
    WDATA   <= d;
    WSTRB   <= s;
    AWVALID <= 1'h1;
    WVALID  <= 1'h1;
    aw_ok = 1'h0;
    w_ok  = 1'h0;
    while (!(aw_ok && w_ok))
    begin
      @(posedge CLK);
      aw_ok = aw_ok || AWREADY;
      w_ok  = w_ok || WREADY;
      AWVALID <= !aw_ok;
      WVALID  <= !w_ok;
    end
    do @(posedge CLK); while (!BVALID);
    BREADY <= 1'h1;
    @(posedge CLK);
    r = BRESP;
    BREADY <= 1'h0;
  endtask : wr

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge CLK);
    ARADDR  <= a;
    ARVALID <= 1'h1;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'h0;
    @(posedge CLK);
    RREADY <= 1'h1;
    do @(posedge CLK); while (!RVALID);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'h0;
  endtask : rd_reg

  task automatic put(input logic [4:0] a, input logic [31:0] d);
    wr(a, d, 4'hf, rs);
    chk("bresp", rs, okay);
  endtask : put

  task automatic get(input string what, input logic [4:0] a,
                     input logic [31:0] m, input logic [31:0] e);
    rd_reg(a, rd, rs);
    chk(what, rd & m, e);
    chk("rresp", rs, okay);
  endtask : get

  // cycles from one request pulse to the next
  task automatic wait_req(input int k);
    n = 1;
    @(posedge CLK);
    while (!reqs[k])
    begin
      @(posedge CLK);
      n++;
    end
  endtask : wait_req

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (90000) @(posedge CLK);
    miscompares++;
    conclude();
  end

  initial
  begin
    SRST = 1'h1;
    AWVALID = 1'h0;
    WVALID = 1'h0;
    BREADY = 1'h0;
    ARVALID = 1'h0;
    RREADY = 1'h0;
    AWADDR = 5'h0;
    ARADDR = 5'h0;
    WDATA = 32'h0;
    WSTRB = 4'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (2) @(posedge CLK);
    SRST <= 1'h0;
    foreach (rows[i])
    begin
      if (rows[i].w)
      begin
        wr(rows[i].a, rows[i].d, rows[i].s, rs);
        chk("bresp", rs, rows[i].r);
      end
      rd_reg(rows[i].a, rd, rs);
      chk("rdata", rd, rows[i].e);
      chk("rresp", rs, rows[i].r);
    end
    $display("test register table done");
    put(`DWIT_OFF_CSR0, 32'ha520);
    put(`DWIT_OFF_CNT0, 32'h5af0);
    while (!INTERVAL_IRQ[0]) @(posedge CLK);
    chk("irq", IRQ, 32'h1);
    get("stat", `DWIT_OFF_STAT, 32'h1, 32'h1);
    chk("itv", INTERVAL_IRQ, 32'h1);
    put(`DWIT_OFF_CSR0, 32'ha520);
    get("csr0", `DWIT_OFF_CSR0, 32'hffffffff, 32'hb8);
    put(`DWIT_OFF_CSR0, 32'ha5a0);
    get("csr0", `DWIT_OFF_CSR0, 32'hffffffff, 32'hb8);
    put(`DWIT_OFF_CSR0, 32'ha520);
    get("csr0", `DWIT_OFF_CSR0, 32'hffffffff, 32'h38);
    chk("itv", INTERVAL_IRQ, 32'h0);
    chk("irq", IRQ, 32'h1);
    put(`DWIT_OFF_EN, 32'h0);
    chk("irq", IRQ, 32'h0);
    put(`DWIT_OFF_EN, 32'h3f);
    chk("irq", IRQ, 32'h1);
    put(`DWIT_OFF_CLR, 32'h3f);
    chk("irq", IRQ, 32'h0);
    put(`DWIT_OFF_CSR0, 32'ha500);
    $display("test interval overflow done");
    for (int i = 0; i < 2; i++)
    begin
      put(`DWIT_OFF_CSR0, 32'ha560 | i);
      wait_req(0);
      wait_req(0);
      chk("period", n, i ? 32'h4000 : 32'h200);
    end
    get("stat", `DWIT_OFF_STAT, 32'h4, 32'h4);
    // channel 0 reset action clears the flag
    put(`DWIT_OFF_ACT0, 32'h1);
    put(`DWIT_OFF_CNT0, 32'h5af0);
    wait_req(2);
    get("csr0", `DWIT_OFF_CSR0, 32'hffffffff, 32'h79);
    get("stat", `DWIT_OFF_STAT, 32'h10, 32'h10);
    put(`DWIT_OFF_CSR0, 32'ha500);
    $display("test channel 0 watchdog done");
    put(`DWIT_OFF_CSR1, 32'ha578);
    wait_req(3);
    wait_req(3);
    chk("sub period", n, 32'h1000);
    get("csr1", `DWIT_OFF_CSR1, 32'hffffffff, 32'h78);
    get("stat", `DWIT_OFF_STAT, 32'h20, 32'h20);
    put(`DWIT_OFF_CSR1, 32'ha560);
    put(`DWIT_OFF_CNT1, 32'h5af0);
    wait_req(1);
    get("stat", `DWIT_OFF_STAT, 32'h8, 32'h8);
    $display("test channel 1 done");
    SRST <= 1'h1;
    repeat (2) @(posedge CLK);
    SRST <= 1'h0;
    for (int i = 0; i < 8; i++)
      get("reset value", 5'(i * 4), 32'hffffffff,
          i == 1 ? 32'h18 : 32'h0);
    $display("test reset values done");
    conclude();
  end

endmodule : dual_channel_watchdog_interval_timer_tb

`default_nettype wire
